//--- dv/sar_adc_parallel_control_bench.sv
/* Self-checking bench for the converter control block and host model.
   Assumes default counts except a short wake wait. */
`timescale 1ns/1ps
`default_nettype none

module sar_adc_parallel_control_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] conv_code = 14'h0000;
    logic [13:0] w;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    wire sample_convert_strobe_n, chip_select_n, read_n, byte_select;
    wire nap_enable_n, powerdown_reset_n, busy, sampling, napping, powered_down, result_valid;
    wire [13:0] data_out, data_out_en;

    always #25 clock = ~clock;

    sar_host_model host (.clock(clock), .busy(busy), .data_out(data_out),
        .sample_convert_strobe_n(sample_convert_strobe_n), .chip_select_n(chip_select_n),
        .read_n(read_n), .byte_select(byte_select), .nap_enable_n(nap_enable_n),
        .powerdown_reset_n(powerdown_reset_n));

    sar_adc_parallel_control #(.WAKE_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n),
        .sample_convert_strobe_n(sample_convert_strobe_n), .chip_select_n(chip_select_n),
        .read_n(read_n), .byte_select(byte_select), .nap_enable_n(nap_enable_n),
        .powerdown_reset_n(powerdown_reset_n), .conv_code(conv_code), .busy(busy),
        .sampling(sampling), .napping(napping), .powered_down(powered_down),
        .result_valid(result_valid), .data_out(data_out), .data_out_en(data_out_en));

    task check(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task complete_run();
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task t_init();
        for (int i = 0; i < 5; i++)
        begin
            conv_code = 14'h2a50 + i[13:0];
            host.convert();
            check({13'h0000, result_valid}, {13'h0000, i == 4});
            host.read(1'b0, w);
            check(w, conv_code);
        end
        host.read(1'b1, w);
        check(w, {conv_code[5:0], 8'h00});
    endtask

    // Read strobe held low so the queue fills and the ninth result stalls
    task t_fifo();
        host.read_n = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            conv_code = 14'h0100 + i[13:0];
            host.convert();
        end
        check({13'h0000, busy}, 14'h0001);
        host.read_n = 1'b1;
        repeat (20) @(negedge clock);
        check({13'h0000, busy}, 14'h0000);
        host.read(1'b0, w);
        check(w, 14'h0108);
    endtask

    task t_nap();
        host.nap_enable_n = 1'b0;
        host.start();
        host.drive(1'b0, 1'b0, 3);
        check({13'h0000, napping}, 14'h0001);
        host.drive(1'b1, 1'b0, 2);
        check({12'h000, napping, sampling}, 14'h0001);
        host.nap_enable_n = 1'b1;
        host.convert();
    endtask

    task t_abort();
        conv_code = 14'h1234;
        host.drive(1'b0, 1'b0, 1);
        host.drive(1'b1, 1'b0, 1);
        host.drive(1'b1, 1'b1, 1);
        host.drive(1'b1, 1'b0, 3);
        check({12'h000, busy, result_valid}, 14'h0000);
        host.read(1'b0, w);
        check(w, 14'h3f80);
        host.drive(1'b1, 1'b0, 1);
        host.drive(1'b0, 1'b0, 1);
        host.drive(1'b1, 1'b0, 7);
        check({12'h000, busy, sampling}, 14'h0001);
    endtask

    // Short low pulse: reset phase only, no powerdown, init count restarts
    task t_short_reset();
        host.powerdown_reset_n = 1'b0;
        host.read(1'b0, w);
        check(w, 14'h3f80);
        host.powerdown_reset_n = 1'b1;
        repeat (2) @(negedge clock);
        check({11'h000, busy, sampling, powered_down}, 14'h0000);
        conv_code = 14'h0abc;
        host.convert();
        check({13'h0000, result_valid}, 14'h0000);
    endtask

    task t_power();
        host.powerdown_reset_n = 1'b0;
        repeat (3) @(negedge clock);
        host.read(1'b0, w);
        check(w, 14'h3f80);
        repeat (150) @(negedge clock);
        check({13'h0000, powered_down}, 14'h0001);
        host.powerdown_reset_n = 1'b1;
        repeat (5) @(negedge clock);
        check({13'h0000, powered_down}, 14'h0001);
        repeat (25) @(negedge clock);
        check({13'h0000, powered_down}, 14'h0000);
        host.convert();
        check({13'h0000, result_valid}, 14'h0000);
    endtask

    initial
    begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_init();
        t_fifo();
        t_nap();
        t_abort();
        t_short_reset();
        t_power();
        complete_run();
    end
endmodule

`default_nettype wire

//--- dv/sar_ctrl_checker_sva.sv
/* Port checker for the converter control block.
   Assumes the default conversion length of five cycles; bound below. */
`timescale 1ns/1ps
`default_nettype none

module sar_ctrl_checker #(
    parameter POWERDOWN_CYCLES = 144
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Strobes
    input wire logic sample_convert_strobe_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic byte_select,
    input wire logic nap_enable_n,
    input wire logic powerdown_reset_n,
    // Status and bus
    input wire logic busy,
    input wire logic sampling,
    input wire logic napping,
    input wire logic powered_down,
    input wire logic [13:0] data_out,
    input wire logic [13:0] data_out_en
);
    // ----------------
    // Low-time count
    // ----------------
    // Saturates so a long powerdown cannot wrap it
    logic [7:0] low_cnt_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt_r <= 8'h00;
        else if (powerdown_reset_n)
            low_cnt_r <= 8'h00;
        else if (low_cnt_r != 8'hff)
            low_cnt_r <= low_cnt_r + 8'h01;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_bus_drive: assert property (!chip_select_n && !read_n |=> data_out_en == 14'h3fff)
        else $error("bus not driven during read");
    a_bus_release: assert property (chip_select_n || read_n |=> data_out_en == 14'h0000)
        else $error("bus driven outside read");
    a_fold_zeros: assert property ($past(byte_select) && !$past(read_n)
        && !$past(chip_select_n) |-> data_out[7:0] == 8'h00)
        else $error("folded word has ones below");
    a_strobe_sample: assert property ($rose(sample_convert_strobe_n) && !chip_select_n
        && !busy && !sampling && !powered_down && powerdown_reset_n |=> sampling)
        else $error("strobe rise did not start sampling");
    a_select_sample: assert property ($fell(chip_select_n) && sample_convert_strobe_n
        && !busy && !sampling && !powered_down && powerdown_reset_n |=> sampling)
        else $error("select fall did not start sampling");
    a_busy_start: assert property ($fell(sample_convert_strobe_n) && !chip_select_n
        && sampling && !busy && powerdown_reset_n |=> busy)
        else $error("conversion did not start");
    a_busy_hold: assert property (($rose(busy) && !chip_select_n && read_n)
        ##1 (!chip_select_n && read_n) [*4] |-> busy ##1 !busy)
        else $error("busy length wrong");
    a_abort_stop: assert property ($fell(chip_select_n) && busy && sample_convert_strobe_n
        |=> !busy && sampling)
        else $error("abort not taken");
    a_nap_entry: assert property ($fell(busy) && !sampling && !nap_enable_n
        && powerdown_reset_n |-> ##[0:2] napping)
        else $error("nap not entered");
    a_nap_quiet: assert property (napping |-> !busy && !sampling)
        else $error("nap while active");
    a_reset_stop: assert property (!powerdown_reset_n [*3] |-> !busy && !sampling)
        else $error("activity in reset phase");
    a_pd_late: assert property (low_cnt_r == POWERDOWN_CYCLES + 4 |-> powered_down)
        else $error("powerdown not entered");
    a_pd_early: assert property (low_cnt_r == POWERDOWN_CYCLES - 4 |-> !powered_down)
        else $error("powerdown entered early");

    c_abort: cover property ($fell(chip_select_n) && busy && sample_convert_strobe_n);
    c_powerdown: cover property ($rose(powered_down));
    c_nap: cover property ($rose(napping));
endmodule

bind sar_adc_parallel_control sar_ctrl_checker #(.POWERDOWN_CYCLES(POWERDOWN_CYCLES)) chk (
    .clock(clock), .rst_n(rst_n), .sample_convert_strobe_n(sample_convert_strobe_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .byte_select(byte_select),
    .nap_enable_n(nap_enable_n), .powerdown_reset_n(powerdown_reset_n), .busy(busy),
    .sampling(sampling), .napping(napping), .powered_down(powered_down),
    .data_out(data_out), .data_out_en(data_out_en));

`default_nettype wire

//--- dv/sar_host_model.sv
/* Host controller model: drives the converter strobes from tasks.
   Assumes the bench calls its tasks at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none

module sar_host_model (
    // Clock and status
    input wire logic clock,
    input wire logic busy,
    input wire logic [13:0] data_out,
    // Strobes
    output logic sample_convert_strobe_n,
    output logic chip_select_n,
    output logic read_n,
    output logic byte_select,
    output logic nap_enable_n,
    output logic powerdown_reset_n
);
    initial
    begin
        sample_convert_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        read_n = 1'b1;
        byte_select = 1'b0;
        nap_enable_n = 1'b1;
        powerdown_reset_n = 1'b1;
    end

    task drive(input logic s, input logic c, input int n);
        sample_convert_strobe_n = s;
        chip_select_n = c;
        repeat (n) @(negedge clock);
    endtask

    // Three cycles of acquisition, enough even after nap
    task start();
        int k;
        drive(1'b1, 1'b0, 3);
        drive(1'b0, 1'b0, 2);
        for (k = 0; k < 40 && busy; k++) @(negedge clock);
    endtask

    // Slow rate: strobe rises only after busy is low, or after 40 cycles of busy
    task convert();
        start();
        drive(1'b1, 1'b0, 1);
        drive(1'b1, 1'b1, 2);
    endtask

    // Read at once, without waiting for the conversion to end
    task read(input logic b, output logic [13:0] w);
        read_n = 1'b0;
        byte_select = b;
        drive(sample_convert_strobe_n, 1'b0, 2);
        w = data_out;
        read_n = 1'b1;
        byte_select = 1'b0;
        drive(sample_convert_strobe_n, 1'b1, 1);
    endtask
endmodule

`default_nettype wire

//--- include/sar_ctrl_regs.vh
/*
 * Timing counts, marker code and layout constants for the converter
 * control block. Assumes a 20 MHz system clock (50 ns period).
 */
`ifndef SAR_CTRL_REGS_VH
`define SAR_CTRL_REGS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 273
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define RESET_PHASE_NS 6140
`define RESET_PHASE_CYCLES ((`RESET_PHASE_NS) / (`CLK_PERIOD_NS))
`define POWERDOWN_NS 7200
`define POWERDOWN_CYCLES (((`POWERDOWN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define WAKE_TIME_MS 25
`define WAKE_CYCLES (((`WAKE_TIME_MS) * 1000000) / (`CLK_PERIOD_NS))

// ----------------------------------------
// Data layout
// ----------------------------------------
`define RESULT_W 14
`define MARKER_CODE 14'h3F80
`define FOLD_BITS 6
`define INIT_CONVS 4
`define FIFO_DEPTH 8

`endif

//--- verilog/sar_adc_parallel_control.v
/*
 * Digital control and parallel readout of a 14-bit SAR converter:
 * sampling/conversion start, abort, busy, read bus, nap, reset/powerdown.
 * Assumes all strobes are synchronous to clock; analog core supplies
 * a 14-bit code on conv_code when a conversion ends.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_regs.vh"

module sar_adc_parallel_control #(
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter POWERDOWN_CYCLES = `POWERDOWN_CYCLES,
    parameter WAKE_CYCLES = `WAKE_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Control strobes
    input wire sample_convert_strobe_n,
    input wire chip_select_n,
    input wire read_n,
    input wire byte_select,
    input wire nap_enable_n,
    input wire powerdown_reset_n,
    // Analog core result
    input wire [`RESULT_W-1:0] conv_code,
    // Status
    output reg busy,
    output reg sampling,
    output reg napping,
    output reg powered_down,
    output reg result_valid,
    // Data bus
    output reg [`RESULT_W-1:0] data_out,
    output reg [`RESULT_W-1:0] data_out_en
);

    localparam ST_IDLE = 3'd0;
    localparam ST_SAMPLE = 3'd1;
    localparam ST_CONV = 3'd2;
    localparam ST_RESET = 3'd3;
    localparam ST_PDOWN = 3'd4;
    localparam ST_WAKE = 3'd5;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg conv_q_r;
    reg cs_q_r;
    reg [24:0] count_r;
    reg [24:0] count_nxt;
    reg [2:0] init_r;
    reg [2:0] init_nxt;
    reg nap_hold_r;
    reg nap_hold_nxt;
    reg push_nxt;
    reg [`RESULT_W:0] push_data_nxt;
    wire conv_rise;
    wire conv_fall;
    wire cs_fall;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`RESULT_W:0] fifo_out_data;
    reg [`RESULT_W-1:0] shown_r;
    reg shown_valid_r;
    wire [`RESULT_W-1:0] bus_word;

    assign conv_rise = sample_convert_strobe_n && !conv_q_r;
    assign conv_fall = !sample_convert_strobe_n && conv_q_r;
    assign cs_fall = !chip_select_n && cs_q_r;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @*
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        init_nxt = init_r;
        nap_hold_nxt = nap_hold_r;
        push_nxt = 1'b0;
        push_data_nxt = {1'b0, `MARKER_CODE};
        case (state_r)
            ST_IDLE:
            begin
                if ((conv_rise && !chip_select_n)
                    || (cs_fall && sample_convert_strobe_n))
                begin
                    state_nxt = ST_SAMPLE;
                    nap_hold_nxt = 1'b0;
                end
                else if (conv_fall && !chip_select_n
                    || cs_fall && !sample_convert_strobe_n)
                begin
                    state_nxt = ST_CONV;
                    count_nxt = 25'd0;
                end
            end
            ST_SAMPLE:
            begin
                if ((conv_fall && !chip_select_n)
                    || (cs_fall && !sample_convert_strobe_n))
                begin
                    state_nxt = ST_CONV;
                    count_nxt = 25'd0;
                end
            end
            ST_CONV:
            begin
                if (cs_fall && sample_convert_strobe_n)
                begin
                    push_nxt = 1'b1;
                    push_data_nxt = {1'b0, `MARKER_CODE};
                    state_nxt = ST_SAMPLE;
                end
                else if (count_r == CONV_CYCLES[24:0] - 25'd1)
                begin
                    // Stall at conversion end while the FIFO is full
                    if (fifo_in_ready)
                    begin
                        push_nxt = 1'b1;
                        push_data_nxt = {(init_r == `INIT_CONVS), conv_code};
                        if (init_r != `INIT_CONVS)
                        begin
                            init_nxt = init_r + 3'd1;
                        end
                        if (!chip_select_n && sample_convert_strobe_n)
                        begin
                            state_nxt = ST_SAMPLE;
                        end
                        else
                        begin
                            state_nxt = ST_IDLE;
                            nap_hold_nxt = !nap_enable_n;
                        end
                    end
                end
                else
                begin
                    count_nxt = count_r + 25'd1;
                end
            end
            ST_RESET:
            begin
                if (powerdown_reset_n)
                begin
                    state_nxt = ST_IDLE;
                    init_nxt = 3'd0;
                end
                else if (count_r >= POWERDOWN_CYCLES[24:0])
                begin
                    state_nxt = ST_PDOWN;
                end
                else
                begin
                    count_nxt = count_r + 25'd1;
                end
            end
            ST_PDOWN:
            begin
                if (powerdown_reset_n)
                begin
                    state_nxt = ST_WAKE;
                    count_nxt = 25'd0;
                end
            end
            ST_WAKE:
            begin
                if (count_r >= WAKE_CYCLES[24:0] - 25'd1)
                begin
                    state_nxt = ST_IDLE;
                    init_nxt = 3'd0;
                end
                else
                begin
                    count_nxt = count_r + 25'd1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!powerdown_reset_n && state_r != ST_RESET && state_r != ST_PDOWN)
        begin
            state_nxt = ST_RESET;
            count_nxt = 25'd0;
            push_nxt = 1'b0;
        end
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            count_r <= 25'd0;
            init_r <= 3'd0;
            nap_hold_r <= 1'b0;
            conv_q_r <= 1'b1;
            cs_q_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            init_r <= init_nxt;
            nap_hold_r <= nap_hold_nxt;
            conv_q_r <= sample_convert_strobe_n;
            cs_q_r <= chip_select_n;
        end
    end

    // ----------------------------------------
    // Result FIFO and readout
    // ----------------------------------------
    // Bus shows the newest popped word, or the marker code while in reset; FIFO drains whenever read_n is high
    sar_result_fifo #(
        .WIDTH(`RESULT_W + 1),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(push_nxt),
        .in_ready(fifo_in_ready),
        .in_data(push_data_nxt),
        .out_valid(fifo_out_valid),
        .out_ready(read_n),
        .out_data(fifo_out_data)
    );

    assign bus_word = byte_select
        ? {shown_r[`FOLD_BITS-1:0], {(`RESULT_W-`FOLD_BITS){1'b0}}}
        : shown_r;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shown_r <= `MARKER_CODE;
            shown_valid_r <= 1'b0;
            busy <= 1'b0;
            sampling <= 1'b0;
            napping <= 1'b0;
            powered_down <= 1'b0;
            result_valid <= 1'b0;
            data_out <= {`RESULT_W{1'b0}};
            data_out_en <= {`RESULT_W{1'b0}};
        end
        else
        begin
            if (state_nxt == ST_RESET)
            begin
                shown_r <= `MARKER_CODE;
                shown_valid_r <= 1'b0;
            end
            else if (fifo_out_valid && read_n)
            begin
                shown_r <= fifo_out_data[`RESULT_W-1:0];
                shown_valid_r <= fifo_out_data[`RESULT_W];
            end
            busy <= (state_nxt == ST_CONV);
            sampling <= (state_nxt == ST_SAMPLE);
            napping <= (state_nxt == ST_IDLE) && nap_hold_nxt && !nap_enable_n
                || (state_nxt == ST_IDLE) && !nap_enable_n;
            powered_down <= (state_nxt == ST_PDOWN) || (state_nxt == ST_WAKE);
            result_valid <= shown_valid_r && (shown_r != `MARKER_CODE);
            data_out <= bus_word;
            data_out_en <= {`RESULT_W{!chip_select_n && !read_n}};
        end
    end

endmodule

`default_nettype wire

//--- verilog/sar_result_fifo.v
/*
 * Result FIFO: parameterised width and depth, flip-flop storage,
 * valid/ready on both sides. Assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_result_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clock)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire
